//--- hw/ihsld_drive.sv
// Cartridge drive top: pin synchronisers, block decode and three heads
`timescale 1ns/1ns
module ihsld_drive
	import ihsld_pkg::*;
#(
	parameter logic KIND_IS_BLACK = KIND_BLACK
)
(
	// Clock, reset and enable
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Shared link pins
	input wire logic xfer_clk,
	input wire logic data_latch,
	input wire logic block_sel_0,
	input wire logic block_sel_1,
	input wire logic block_sel_2,
	input wire logic block_sel_3,
	// Head a pins
	input wire logic head_a_even_bits,
	input wire logic head_a_odd_bits,
	input wire logic head_a_firing_gate,
	input wire logic head_a_short_pulse_gate,
	// Head b pins
	input wire logic head_b_even_bits,
	input wire logic head_b_odd_bits,
	input wire logic head_b_firing_gate,
	input wire logic head_b_short_pulse_gate,
	// Head c pins
	input wire logic head_c_even_bits,
	input wire logic head_c_odd_bits,
	input wire logic head_c_firing_gate,
	input wire logic head_c_short_pulse_gate,
	// Heater lines, low energises
	output logic [HEATER_N-1:0] head_a_heater_n,
	output logic [HEATER_N-1:0] head_b_heater_n,
	output logic [HEATER_N-1:0] head_c_heater_n,
	// Kind pad, open drain
	output logic head_kind_pin_o,
	output logic head_kind_pin_oe_n
);
	logic [SYNC_W-1:0] pin_vec;
	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic xfer_prev_r;
	logic latch_prev_r;
	logic shift_pulse;
	logic latch_pulse;
	logic [BLOCK_SEL_W-1:0] block_code;
	logic [BLOCK_N-1:0] block_onehot;
	logic [HEAD_N-1:0] even_s;
	logic [HEAD_N-1:0] odd_s;
	logic [HEAD_N-1:0] fire_s;
	logic [HEAD_N-1:0] short_s;
	logic [HEAD_N-1:0] heat_on;
	logic [HEATER_N-1:0] heater_arr [HEAD_N];
	logic [7:0] shift_cnt_r;

	// Gather every pin so one synchroniser pair handles them all
	assign pin_vec[POS_XFER] = xfer_clk;
	assign pin_vec[POS_LATCH] = data_latch;
	assign pin_vec[POS_BSEL+3:POS_BSEL] = {block_sel_3, block_sel_2, block_sel_1, block_sel_0};
	assign pin_vec[POS_EVEN+2:POS_EVEN] = {head_c_even_bits, head_b_even_bits, head_a_even_bits};
	assign pin_vec[POS_ODD+2:POS_ODD] = {head_c_odd_bits, head_b_odd_bits, head_a_odd_bits};
	assign pin_vec[POS_FIRE+2:POS_FIRE] =
		{head_c_firing_gate, head_b_firing_gate, head_a_firing_gate};
	assign pin_vec[POS_SHORT+2:POS_SHORT] =
		{head_c_short_pulse_gate, head_b_short_pulse_gate, head_a_short_pulse_gate};

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			sync1_r <= SYNC_RST;
		else if (clk_en)
			sync1_r <= pin_vec;
	end

	// Data and clock share the same delay, so the bit stays aligned with its edge
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			sync2_r <= SYNC_RST;
		else if (clk_en)
			sync2_r <= sync1_r;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			xfer_prev_r <= 1'b0;
			latch_prev_r <= 1'b0;
		end
		else if (clk_en)
		begin
			xfer_prev_r <= sync2_r[POS_XFER];
			latch_prev_r <= sync2_r[POS_LATCH];
		end
	end

	// Rising edges only; the link clock must stay well below the system rate
	assign shift_pulse = sync2_r[POS_XFER] & ~xfer_prev_r;
	assign latch_pulse = sync2_r[POS_LATCH] & ~latch_prev_r;

	assign block_code = sync2_r[POS_BSEL+3:POS_BSEL];
	for (genvar b = 0; b < BLOCK_N; b++)
	begin : g_decode
		assign block_onehot[b] = (block_code == BLOCK_SEL_W'(b));
	end

	assign even_s = sync2_r[POS_EVEN+2:POS_EVEN];
	assign odd_s = sync2_r[POS_ODD+2:POS_ODD];
	assign fire_s = sync2_r[POS_FIRE+2:POS_FIRE];
	assign short_s = sync2_r[POS_SHORT+2:POS_SHORT];

	// Either gate drives; the controller sequences pre-heat then main heat
	assign heat_on = fire_s | short_s;

	for (genvar h = 0; h < HEAD_N; h++)
	begin : g_head
		ihsld_head #(
			.SW(SHIFT_W),
			.BN(BLOCK_N)
		) u_head (
			.sys_clk(sys_clk),
			.reset_n(reset_n),
			.clk_en(clk_en),
			.shift_pulse(shift_pulse),
			.latch_pulse(latch_pulse),
			.block_onehot(block_onehot),
			.even_bit(even_s[h]),
			.odd_bit(odd_s[h]),
			.heat_on(heat_on[h]),
			.heater_n(heater_arr[h])
		);
	end

	assign head_a_heater_n = heater_arr[0];
	assign head_b_heater_n = heater_arr[1];
	assign head_c_heater_n = heater_arr[2];

	// Black pad floats high on its pull-up, the others tie to ground
	assign head_kind_pin_o = 1'b0;
	assign head_kind_pin_oe_n = KIND_IS_BLACK;

	// Helper count of shifts since the last latch, read only by checks
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			shift_cnt_r <= 8'h00;
		else if (clk_en && latch_pulse)
			shift_cnt_r <= 8'h00;
		else if (clk_en && shift_pulse && shift_cnt_r != 8'hFF)
			shift_cnt_r <= shift_cnt_r + 8'h01;
	end

	sequence s_xfer_high_held;
		clk_en && xfer_clk ##1 clk_en && xfer_clk ##1 clk_en && xfer_clk;
	endsequence

	sequence s_xfer_low_before;
		clk_en && !sync2_r[POS_XFER];
	endsequence

	sequence s_latch_rise;
		clk_en && !data_latch ##1 clk_en && data_latch ##1 clk_en && data_latch;
	endsequence

	a_block_onehot_sel: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$onehot(block_onehot))
		else $error("block decode not one-hot");
	a_block_code_map: assert property (@(posedge sys_clk) disable iff (!reset_n)
		block_onehot[block_code])
		else $error("decoded block differs from code");
	a_xfer_edge_seen: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_xfer_low_before ##0 (sync1_r[POS_XFER] && clk_en) |=> shift_pulse)
		else $error("transfer clock edge missed");
	a_xfer_sync_lat: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_xfer_high_held |-> sync2_r[POS_XFER])
		else $error("transfer clock not through two stages");
	a_latch_sync_lat: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_latch_rise |=> latch_pulse)
		else $error("latch strobe lost in synchroniser");
	a_single_shift: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && shift_pulse |=> !shift_pulse)
		else $error("one link edge gave two shifts");
	a_heat_idle_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && heat_on == 3'b000 |=> &head_a_heater_n && &head_b_heater_n
		&& &head_c_heater_n)
		else $error("heater on with all gates off");
	a_short_gate_fire: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && short_s[0] |-> heat_on[0])
		else $error("short pulse gate did not enable head a");
	a_kind_pad_level: assert property (@(posedge sys_clk) disable iff (!reset_n)
		head_kind_pin_oe_n == KIND_IS_BLACK && !head_kind_pin_o)
		else $error("kind pad drive wrong");
	a_shift_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && latch_pulse |=> shift_cnt_r == 8'h00)
		else $error("shift count not cleared by latch");
endmodule : ihsld_drive

//--- hw/ihsld_pkg.sv
// Shared constants for the inkjet head shift, latch and heater drive block
package ihsld_pkg;
	localparam int HEAD_N = 3;
	localparam int SHIFT_W = 8;
	localparam int BLOCK_N = 16;
	localparam int BLOCK_SEL_W = 4;
	localparam int NOZZLE_ROW_N = 128;
	localparam int HEATER_N = 256;
	localparam int EVEN_HEATER_LAST = 254;
	localparam int ODD_HEATER_LAST = 255;
	localparam int SYNC_W = 6 + 4 * HEAD_N;
	localparam logic [7:0] SHIFT_RST = 8'h00;
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [255:0] HEATER_IDLE = {32{8'hFF}};
	localparam logic [17:0] SYNC_RST = 18'h00000;
	localparam logic KIND_BLACK = 1'b1;
	localparam int POS_XFER = 0;
	localparam int POS_LATCH = 1;
	localparam int POS_BSEL = 2;
	localparam int POS_EVEN = 6;
	localparam int POS_ODD = 6 + HEAD_N;
	localparam int POS_FIRE = 6 + 2 * HEAD_N;
	localparam int POS_SHORT = 6 + 3 * HEAD_N;
endpackage : ihsld_pkg

//--- hw/ihsld_head.sv
// One head: two 8-bit shift registers, their latches and the gated heater drive
`timescale 1ns/1ns
module ihsld_head
	import ihsld_pkg::*;
#(
	parameter int SW = SHIFT_W,
	parameter int BN = BLOCK_N
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Common link strobes, already synchronised
	input wire logic shift_pulse,
	input wire logic latch_pulse,
	input wire logic [BN-1:0] block_onehot,
	// Per head data and heat gate
	input wire logic even_bit,
	input wire logic odd_bit,
	input wire logic heat_on,
	// Heater interface, low energises
	output logic [2*SW*BN-1:0] heater_n
);
	logic [SW-1:0] even_sr_r;
	logic [SW-1:0] odd_sr_r;
	logic [SW-1:0] even_lat_r;
	logic [SW-1:0] odd_lat_r;
	logic [2*SW*BN-1:0] heater_nxt;

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			even_sr_r <= SHIFT_RST;
			odd_sr_r <= SHIFT_RST;
		end
		else if (clk_en && shift_pulse)
		begin
			even_sr_r <= {even_sr_r[SW-2:0], even_bit};
			odd_sr_r <= {odd_sr_r[SW-2:0], odd_bit};
		end
	end

	// A latch in the same cycle as a shift takes the contents before that shift
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			even_lat_r <= LATCH_RST;
			odd_lat_r <= LATCH_RST;
		end
		else if (clk_en && latch_pulse)
		begin
			even_lat_r <= even_sr_r;
			odd_lat_r <= odd_sr_r;
		end
	end

	// Heater 2*(8*block+bit) is even, the next one odd, matching nozzle order
	for (genvar b = 0; b < BN; b++)
	begin : g_block
		for (genvar i = 0; i < SW; i++)
		begin : g_bit
			assign heater_nxt[2*(SW*b+i)] = ~(heat_on & block_onehot[b] & even_lat_r[i]);
			assign heater_nxt[2*(SW*b+i)+1] = ~(heat_on & block_onehot[b] & odd_lat_r[i]);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			heater_n <= HEATER_IDLE;
		else if (clk_en)
			heater_n <= heater_nxt;
	end

	a_shift_even_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && shift_pulse |=> even_sr_r == {$past(even_sr_r[SW-2:0]), $past(even_bit)})
		else $error("even shift register did not take the bit");
	a_shift_odd_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && shift_pulse |=> odd_sr_r == {$past(odd_sr_r[SW-2:0]), $past(odd_bit)})
		else $error("odd shift register did not take the bit");
	a_latch_capture: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && latch_pulse |=> even_lat_r == $past(even_sr_r) && odd_lat_r == $past(odd_sr_r))
		else $error("latch did not capture shift contents");
	a_latch_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!latch_pulse |=> $stable(even_lat_r) && $stable(odd_lat_r))
		else $error("latch changed without a strobe");
	a_fire_low_drive: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && heat_on && block_onehot[0] && even_lat_r[0] |=> !heater_n[0])
		else $error("selected heater not pulled low");
	a_other_block_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clk_en && !block_onehot[BN-1] |=> &heater_n[2*SW*BN-1:2*SW*(BN-1)])
		else $error("unselected block heater energised");
endmodule : ihsld_head

//--- tb/ihsld_ctrl_model.sv
// Printer side controller model driving the cartridge link pins
`timescale 1ns/1ns
module ihsld_ctrl_model
	import ihsld_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Shared link pins
	output logic xfer_clk,
	output logic data_latch,
	output logic [3:0] block_code,
	// Per head lines, index 0 is head a
	output logic [2:0] even_line,
	output logic [2:0] odd_line,
	output logic [2:0] fire_gate,
	output logic [2:0] short_gate
);
	initial
	begin
		{xfer_clk, data_latch, block_code} = '0;
		{even_line, odd_line, fire_gate, short_gate} = '0;
	end
	// Clock stands low outside frames; data is set at the fall, 4 cycles before the rise
	task automatic send_bits(input logic [23:0] ev, input logic [23:0] od, input logic latch);
		for (int b = 7; b >= 0; b--)
		begin
			@(posedge sys_clk);
			xfer_clk <= 1'b0;
			for (int h = 0; h < 3; h++)
			begin
				even_line[h] <= ev[8*h+b];
				odd_line[h] <= od[8*h+b];
			end
			repeat (4) @(posedge sys_clk);
			xfer_clk <= 1'b1;
			repeat (3) @(posedge sys_clk);
		end
		@(posedge sys_clk);
		xfer_clk <= 1'b0;
		// Lines no longer valid, so show the inverse rather than a stale value
		even_line <= ~even_line;
		odd_line <= ~odd_line;
		if (latch)
		begin
			repeat (4) @(posedge sys_clk);
			data_latch <= 1'b1;
			repeat (4) @(posedge sys_clk);
			data_latch <= 1'b0;
		end
	endtask : send_bits
	// Gates low ends the heater pulse; pre and main heat timing is ours
	task automatic set_fire(input logic [3:0] blk, input logic [2:0] fg, input logic [2:0] sg);
		@(posedge sys_clk);
		block_code <= blk;
		fire_gate <= fg;
		short_gate <= sg;
	endtask : set_fire
endmodule : ihsld_ctrl_model

//--- tb/ihsld_drive_bench.sv
// Self-checking bench for the cartridge drive top
`timescale 1ns/1ns
module ihsld_drive_bench
	import ihsld_pkg::*;
;
	logic sys_clk, reset_n, clk_en, xfer_clk, data_latch;
	logic [3:0] bcode;
	logic [2:0] ev_l, od_l, fg_l, sg_l;
	logic [255:0] heat [3];
	logic kind_o, kind_oe_n;
	int seed = 99;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	logic [23:0] ev, od;
	logic [3:0] blk;
	logic [2:0] fg, sg;
	ihsld_ctrl_model ctrl (.sys_clk(sys_clk), .xfer_clk(xfer_clk), .data_latch(data_latch),
		.block_code(bcode), .even_line(ev_l), .odd_line(od_l), .fire_gate(fg_l),
		.short_gate(sg_l));
	ihsld_drive uut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
		.xfer_clk(xfer_clk), .data_latch(data_latch), .block_sel_0(bcode[0]),
		.block_sel_1(bcode[1]), .block_sel_2(bcode[2]), .block_sel_3(bcode[3]),
		.head_a_even_bits(ev_l[0]), .head_a_odd_bits(od_l[0]),
		.head_a_firing_gate(fg_l[0]), .head_a_short_pulse_gate(sg_l[0]),
		.head_b_even_bits(ev_l[1]), .head_b_odd_bits(od_l[1]),
		.head_b_firing_gate(fg_l[1]), .head_b_short_pulse_gate(sg_l[1]),
		.head_c_even_bits(ev_l[2]), .head_c_odd_bits(od_l[2]),
		.head_c_firing_gate(fg_l[2]), .head_c_short_pulse_gate(sg_l[2]),
		.head_a_heater_n(heat[0]), .head_b_heater_n(heat[1]), .head_c_heater_n(heat[2]),
		.head_kind_pin_o(kind_o), .head_kind_pin_oe_n(kind_oe_n));
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic complete_run();
		if (miscompares == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	always @(posedge sys_clk)
	begin
		cycles++;
		// Expected run is near 2100 cycles
		if (cycles == 10000)
		begin
			miscompares++;
			complete_run();
		end
	end
	task automatic check(input logic [255:0] seen, input logic [255:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Low bit means energised; bit i of a latch lands on heater 2*(8*block+i) or the next
	function automatic logic [255:0] exp_heat(logic [7:0] e, logic [7:0] o, int b, logic on);
		logic [255:0] r;
		r = HEATER_IDLE;
		if (on)
			for (int i = 0; i < 8; i++)
			begin
				r[2*(8*b+i)] = ~e[i];
				r[2*(8*b+i)+1] = ~o[i];
			end
		return r;
	endfunction : exp_heat
	task automatic check_all();
		repeat (6) @(posedge sys_clk);
		for (int h = 0; h < 3; h++)
			check(heat[h], exp_heat(ev[8*h+:8], od[8*h+:8], int'(blk), fg[h] | sg[h]));
	endtask : check_all
	task automatic fire_check(input logic [3:0] b, input logic [2:0] f, input logic [2:0] s);
		blk = b;
		fg = f;
		sg = s;
		ctrl.set_fire(blk, fg, sg);
		check_all();
	endtask : fire_check
	initial
	begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		ev = '0;
		od = '0;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		// Cleared latches keep every heater idle even with all gates on
		fire_check(4'h0, 3'h7, 3'h7);
		check(256'(kind_o), 256'h0);
		check(256'(kind_oe_n), 256'(KIND_BLACK));
		for (int n = 0; n < 12; n++)
		begin
			ev = 24'($random(seed));
			od = 24'($random(seed));
			ctrl.send_bits(ev, od, 1'b1);
			fire_check(4'($random(seed)), 3'($random(seed)), 3'($random(seed)));
			// New bits shifted without a strobe must not reach the heaters
			ctrl.send_bits(~ev, ~od, 1'b0);
			check_all();
			fire_check(blk, 3'h0, 3'h0);
		end
		ev = 24'h80A501;
		od = 24'h015A80;
		ctrl.send_bits(ev, od, 1'b1);
		for (int b = 0; b < 16; b++)
			fire_check(b[3:0], 3'b101, 3'b010);
		// Enable low freezes the heaters although the gates drop, so the old expectation stands
		clk_en <= 1'b0;
		ctrl.set_fire(4'h3, 3'h0, 3'h0);
		check_all();
		clk_en <= 1'b1;
		fire_check(4'h3, 3'h0, 3'h0);
		// Reset in mid-run clears the latches, so gates left on fire nothing
		ctrl.set_fire(4'h3, 3'h7, 3'h7);
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		ev = '0;
		od = '0;
		fire_check(4'h3, 3'h7, 3'h7);
		complete_run();
	end
endmodule : ihsld_drive_bench
